// [verilog/pmic_control_pin_logic.sv]
// Purpose: power-on, standby, host reset and interrupt pin control
// Assumes: inputs synchronous to sys_clk; regulator sequencing outside
// Notes: open-drain pins come out as level and drive enable
//
// Added by the designer: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "pin_cfg.svh"
module pmic_control_pin_logic #(
	parameter int TICK_DIV = `SYS_HZ / `SLOW_HZ,
	parameter int DB_SHORT = int'(`CEIL_TICKS(`T_DB_SHORT_US)),
	parameter int DB_MID = int'(`CEIL_TICKS(`T_DB_MID_US)),
	parameter int DB_LONG = int'(`CEIL_TICKS(`T_DB_LONG_US)),
	parameter int LONG_PRESS = int'(`CEIL_TICKS(`T_LONG_PRESS_US)),
	parameter int FAULT_ASSERT = int'(`CEIL_TICKS(`T_FAULT_ASSERT_US)),
	parameter int FAULT_OFF = int'(`CEIL_TICKS(`T_FAULT_OFF_US)),
	parameter int REL_BASE = int'(`CEIL_TICKS(`T_REL_BASE_US)),
	parameter int AW = 8,
	parameter int DW = 32
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [AW-1:0] addr,
	input wire logic [DW-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [DW-1:0] rdata,
	input wire logic power_on_input,
	input wire logic standby_in,
	input wire logic fault_in,
	input wire logic seq_done,
	output logic regs_on,
	output logic sleep_out,
	output logic standby_out,
	output pin_pkg::od_pin_t host_reset_out_n,
	output pin_pkg::od_pin_t irq_out_n
);
	localparam int CW = 24;

	pin_pkg::ctrl_t ctrl_r;
	pin_pkg::pwr_state_t state_r;
	pin_pkg::pwr_state_t state_nxt;
	logic [15:0] div_r;
	logic tick_r;
	logic key_lvl;
	logic key_fall;
	logic key_rise;
	logic [CW-1:0] fall_len;
	logic [CW-1:0] lp_cnt_r;
	logic long_hit;
	logic [2:0] sb_sync_r;
	logic sb_req;
	logic sb_act_r;
	logic [CW-1:0] sb_cnt_r;
	logic [CW-1:0] hold_len;
	logic sb_flip;
	logic [CW-1:0] flt_cnt_r;
	logic fm;
	logic flt_low;
	logic flt_low_d_r;
	logic flt_kill;
	logic start_flt_r;
	logic [CW-1:0] rel_cnt_r;
	logic [CW-1:0] rel_len;
	logic rel_hit;
	logic turn_on;
	logic turn_off;
	logic hold_rst;
	logic [`IRQ_W-1:0] stat_r;
	logic [`IRQ_W-1:0] stat_nxt;
	logic [`IRQ_W-1:0] mask_r;
	logic [`IRQ_W-1:0] mask_nxt;
	logic [`IRQ_W-1:0] ev;
	logic [`IRQ_W-1:0] clr;
	logic enter_off;

	assign fm = ctrl_r.reset_fault_mode_enable; // see [RQ16]

	// slow clock enable, about 32 kHz from sys_clk
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			div_r <= '0;
			tick_r <= 1'b0;
		end else if (div_r == 16'(TICK_DIV - 1)) begin
			div_r <= '0;
			tick_r <= 1'b1;
		end else begin
			div_r <= div_r + 16'h1;
			tick_r <= 1'b0;
		end
	end

	// register writes
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ctrl_r <= pin_pkg::ctrl_t'(`CTRL_RST);
		end else if (wr && addr == `ADDR_CTRL) begin
			ctrl_r <= pin_pkg::ctrl_t'(wdata[$bits(pin_pkg::ctrl_t)-1:0]);
		end
	end

	always_comb begin
		case (ctrl_r.power_key_debounce_sel) // see [RQ8]
			2'h2: fall_len = CW'(DB_MID);
			2'h3: fall_len = CW'(DB_LONG);
			default: fall_len = CW'(DB_SHORT);
		endcase
	end

	key_debounce #(
		.CW(CW)
	) u_key (
		.sys_clk(sys_clk),
		.rst(rst),
		.tick(tick_r),
		.raw(power_on_input),
		.fall_len(fall_len),
		.rise_len(CW'(DB_SHORT)),
		.level_r(key_lvl),
		.fall_r(key_fall),
		.rise_r(key_rise)
	);

	// long press timer saturates so it fires once per press
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			lp_cnt_r <= '0;
		end else if (key_lvl) begin
			lp_cnt_r <= '0; // see [RQ24]
		end else if (tick_r && lp_cnt_r != CW'(LONG_PRESS)) begin
			lp_cnt_r <= lp_cnt_r + CW'(1);
		end
	end
	assign long_hit = !key_lvl && tick_r
		&& lp_cnt_r == CW'(LONG_PRESS - 1); // see [RQ3]

	// standby synchroniser on the slow clock
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sb_sync_r <= '0;
		end else if (tick_r) begin
			sb_sync_r <= {sb_sync_r[1:0],
				standby_in ^ ctrl_r.standby_polarity_invert}; // see [RQ10]
		end
	end
	assign sb_req = sb_sync_r[2]; // see [RQ12]
	assign hold_len = CW'(`STBY_STEP_TICKS)
		* CW'(ctrl_r.standby_hold_off_delay);
	assign sb_flip = sb_req != sb_act_r && sb_cnt_r >= hold_len;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sb_cnt_r <= '0;
			sb_act_r <= 1'b0;
		end else if (sb_req == sb_act_r) begin
			sb_cnt_r <= '0; // see [RQ24]
		end else if (sb_flip) begin
			sb_act_r <= sb_req; // see [RQ11]
			sb_cnt_r <= '0;
		end else if (tick_r) begin
			sb_cnt_r <= sb_cnt_r + CW'(1);
		end
	end

	// fault persistence, supervised while regulators are up
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			flt_cnt_r <= '0;
		end else if (!fault_in || state_r == pin_pkg::ST_OFF
			|| state_r == pin_pkg::ST_SLEEP) begin
			flt_cnt_r <= '0; // see [RQ24]
		end else if (tick_r && flt_cnt_r != CW'(FAULT_OFF)) begin
			flt_cnt_r <= flt_cnt_r + CW'(1);
		end
	end
	assign flt_low = fm && flt_cnt_r >= CW'(FAULT_ASSERT); // see [RQ14]
	assign flt_kill = fm && flt_cnt_r >= CW'(FAULT_OFF); // see [RQ15]

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			flt_low_d_r <= 1'b0;
		end else begin
			flt_low_d_r <= flt_low;
		end
	end

	// a fault seen anywhere in start-up blocks the release
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			start_flt_r <= 1'b0;
		end else if (state_r != pin_pkg::ST_START) begin
			start_flt_r <= 1'b0;
		end else if (fault_in) begin
			start_flt_r <= 1'b1; // see [RQ14]
		end
	end

	// release delay, timed from the last regulator
	always_comb begin
		if (ctrl_r.reset_release_delay_sel == `REL_TOP_CODE) begin
			rel_len = CW'(REL_BASE) << `REL_TOP_SHIFT; // see [RQ23]
		end else begin
			rel_len = CW'(REL_BASE)
				<< ctrl_r.reset_release_delay_sel; // see [RQ17]
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rel_cnt_r <= '0;
		end else if (state_r != pin_pkg::ST_START || !seq_done) begin
			rel_cnt_r <= '0;
		end else if (tick_r && rel_cnt_r != rel_len) begin
			rel_cnt_r <= rel_cnt_r + CW'(1);
		end
	end
	assign rel_hit = seq_done && rel_cnt_r >= rel_len;

	always_comb begin
		if (ctrl_r.power_input_edge_select) begin // see [RQ1]
			turn_on = key_fall; // see [RQ3]
			turn_off = long_hit && ctrl_r.long_press_off_enable; // see [RQ6]
		end else begin
			turn_on = key_lvl; // see [RQ2]
			turn_off = !key_lvl; // see [RQ2]
		end
	end

	// power state; in edge mode, key edges in run or standby only interrupt
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			pin_pkg::ST_OFF: begin
				if (turn_on) begin
					state_nxt = pin_pkg::ST_START; // see [RQ15]
				end
			end
			pin_pkg::ST_SLEEP: begin
				if (turn_on) begin
					state_nxt = pin_pkg::ST_RUN; // see [RQ4]
				end
			end
			pin_pkg::ST_START: begin
				if (turn_off || flt_kill) begin
					state_nxt = pin_pkg::ST_OFF;
				end else if (rel_hit && !(fm && start_flt_r)) begin
					state_nxt = pin_pkg::ST_RUN; // see [RQ13]
				end
			end
			pin_pkg::ST_RUN, pin_pkg::ST_STBY: begin
				if (turn_off) begin
					state_nxt = ctrl_r.sleep_select ? pin_pkg::ST_SLEEP
						: pin_pkg::ST_OFF;
				end else if (flt_kill) begin
					state_nxt = pin_pkg::ST_OFF; // see [RQ15]
				end else if (sb_act_r) begin
					state_nxt = pin_pkg::ST_STBY; // see [RQ5]
				end else begin
					state_nxt = pin_pkg::ST_RUN;
				end
			end
			default: begin
				state_nxt = pin_pkg::ST_OFF;
			end
		endcase
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_r <= pin_pkg::ST_OFF;
		end else begin
			state_r <= state_nxt;
		end
	end

	// interrupt status and mask; a set beats a clear in the same cycle
	always_comb begin
		ev = '0;
		ev[`IRQ_KEY_FALL] = key_fall; // see [RQ7]
		ev[`IRQ_KEY_RISE] = key_rise; // see [RQ7]
		ev[`IRQ_FAULT] = flt_low && !flt_low_d_r;
		ev[`IRQ_STBY] = sb_flip;
		clr = '0;
		if (wr && addr == `ADDR_STATUS) begin
			clr = wdata[`IRQ_W-1:0]; // see [RQ19]
		end
		enter_off = state_nxt == pin_pkg::ST_OFF
			&& state_r != pin_pkg::ST_OFF;
		stat_nxt = stat_r & ~clr;
		if (enter_off) begin
			stat_nxt = stat_nxt & ~`KEY_BITS; // see [RQ9]
		end
		stat_nxt = stat_nxt | ev; // see [RQ20]
		mask_nxt = mask_r;
		if (wr && addr == `ADDR_MASK) begin
			mask_nxt = wdata[`IRQ_W-1:0];
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			stat_r <= '0;
			mask_r <= `MASK_RST; // see [RQ21]
		end else begin
			stat_r <= stat_nxt; // see [RQ9]
			mask_r <= mask_nxt;
		end
	end

	// irq pin follows next status, so unmasking shows on the same edge as the mask write
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			irq_out_n <= '{lvl: 1'b1, oe: 1'b0};
		end else begin
			irq_out_n.lvl <= ~|(stat_nxt & ~mask_nxt); // see [RQ18]
			irq_out_n.oe <= |(stat_nxt & ~mask_nxt); // see [RQ21]
		end
	end

	// reset held in off and start-up, and on a persisting fault
	assign hold_rst = state_nxt == pin_pkg::ST_OFF
		|| state_nxt == pin_pkg::ST_START
		|| (flt_low && state_nxt != pin_pkg::ST_SLEEP); // see [RQ14]

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			host_reset_out_n <= '{lvl: 1'b0, oe: 1'b1};
			regs_on <= 1'b0;
			sleep_out <= 1'b0;
			standby_out <= 1'b0;
		end else begin
			host_reset_out_n.lvl <= !hold_rst; // see [RQ13]
			host_reset_out_n.oe <= hold_rst;
			regs_on <= state_nxt == pin_pkg::ST_START
				|| state_nxt == pin_pkg::ST_RUN
				|| state_nxt == pin_pkg::ST_STBY;
			sleep_out <= state_nxt == pin_pkg::ST_SLEEP;
			standby_out <= state_nxt == pin_pkg::ST_STBY;
		end
	end

	// register reads; the sense word is live and ignores writes
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rdata <= '0;
		end else if (!rd) begin
			rdata <= '0;
		end else if (addr == `ADDR_CTRL) begin
			rdata <= DW'(ctrl_r);
		end else if (addr == `ADDR_STATUS) begin
			rdata <= DW'(stat_r);
		end else if (addr == `ADDR_MASK) begin
			rdata <= DW'(mask_r);
		end else if (addr == `ADDR_SENSE) begin
			rdata <= DW'({flt_low, fault_in, sb_req, key_lvl}); // see [RQ22]
		end else if (addr == `ADDR_STATE) begin
			rdata <= DW'({sb_act_r, state_r});
		end else begin
			rdata <= '0;
		end
	end
endmodule : pmic_control_pin_logic

// [verilog/pin_cfg.svh]
// Purpose: constants for the power control pin logic
// Assumes: sys_clk at 25 MHz, slow tick at 32768 Hz
// Notes: times in microseconds, counts in slow ticks
// Notes on behaviour
// [RQ1] power-on input is level mode on select 0, edge mode on 1
// [RQ2] level mode: high turns on, low turns off or sleeps
// [RQ3] edge mode: falling edge turns on, long low press turns off
// [RQ4] edge mode: brief press moves off or sleep to run
// [RQ5] brief press in run or standby only raises key interrupt
// [RQ6] long press turns off only when long-press enable is 1
// [RQ7] key interrupt on both falling and rising debounced edges
// [RQ8] debounce select picks 31.25/125/750 ms falling; rising 31.25 ms
// [RQ9] key interrupt holds until cleared or off state is entered
// [RQ10] standby is pin level xor polarity invert bit
// [RQ11] nonzero hold-off delays the whole standby response
// [RQ12] standby pin passes three slow-clock synchroniser stages
// [RQ13] default mode: reset released after start-up, low at turn-off
// [RQ14] fault mode: release only fault-free; low on 1.8 ms fault
// [RQ15] fault mode: fault beyond 100 ms turns off; power-on restarts
// [RQ16] fault mode selected by reset fault mode enable bit
// [RQ17] three-bit field selects release delay from 2 ms to 1024 ms
// [RQ18] interrupt output low while any unmasked status bit is set
// [RQ19] status bits clear by writing 1; output then releases
// [RQ20] masked bits still set and read, but never drive the output
// [RQ21] masks all set at reset; unmasking a set bit asserts output
// [RQ22] sense register is live, read only, unlatched
// [RQ23] release codes are power-of-two steps of 2 ms up to 1024 ms
// [RQ24] timers count slow ticks and restart when condition leaves
`ifndef PIN_CFG_SVH
`define PIN_CFG_SVH
`define SYS_HZ 25000000
`define SLOW_HZ 32768
`define CEIL_TICKS(us) ((64'(us) * `SLOW_HZ + 64'd999999) / 64'd1000000)
`define T_DB_SHORT_US 31250
`define T_DB_MID_US 125000
`define T_DB_LONG_US 750000
`define T_LONG_PRESS_US 4000000
`define T_FAULT_ASSERT_US 1800
`define T_FAULT_OFF_US 100000
`define T_REL_BASE_US 2000
`define REL_TOP_CODE 3'h7
`define REL_TOP_SHIFT 9
`define STBY_STEP_TICKS 32
`define ADDR_CTRL 8'h00
`define ADDR_STATUS 8'h04
`define ADDR_MASK 8'h08
`define ADDR_SENSE 8'h0c
`define ADDR_STATE 8'h10
`define CTRL_RST 12'h000
`define IRQ_W 4
`define MASK_RST 4'hf
`define IRQ_KEY_FALL 0
`define IRQ_KEY_RISE 1
`define IRQ_FAULT 2
`define IRQ_STBY 3
`define KEY_BITS 4'h3
`endif

// [verilog/pin_pkg.sv]
// Purpose: types shared by the power control pin logic
// Assumes: nothing
// Notes: control word layout is the ctrl register layout
package pin_pkg;
	typedef enum logic [2:0] {
		ST_OFF,
		ST_START,
		ST_RUN,
		ST_STBY,
		ST_SLEEP
	} pwr_state_t;
	typedef struct packed {
		logic sleep_select;
		logic [2:0] reset_release_delay_sel;
		logic reset_fault_mode_enable;
		logic [1:0] standby_hold_off_delay;
		logic standby_polarity_invert;
		logic [1:0] power_key_debounce_sel;
		logic long_press_off_enable;
		logic power_input_edge_select;
	} ctrl_t;
	typedef struct packed {
		logic lvl;
		logic oe;
	} od_pin_t;
endpackage : pin_pkg

// [verilog/key_debounce.sv]
// Purpose: debounce the power-on input with separate edge lengths
// Assumes: tick is a one-cycle slow clock enable
// Notes: level rests high, as a released button reads high
`timescale 1ns/1ps
module key_debounce #(
	parameter int CW = 24
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic tick,
	input wire logic raw,
	input wire logic [CW-1:0] fall_len,
	input wire logic [CW-1:0] rise_len,
	output logic level_r,
	output logic fall_r,
	output logic rise_r
);
	logic [CW-1:0] cnt_r;
	logic [CW-1:0] len;

	assign len = level_r ? fall_len : rise_len; // see [RQ8]

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cnt_r <= '0;
			level_r <= 1'b1;
			fall_r <= 1'b0;
			rise_r <= 1'b0;
		end else begin
			fall_r <= 1'b0;
			rise_r <= 1'b0;
			if (raw == level_r) begin
				cnt_r <= '0; // see [RQ24]
			end else if (tick && cnt_r >= len - CW'(1)) begin
				level_r <= raw;
				fall_r <= !raw; // see [RQ7]
				rise_r <= raw; // see [RQ7]
				cnt_r <= '0;
			end else if (tick) begin
				cnt_r <= cnt_r + CW'(1);
			end
		end
	end
endmodule : key_debounce

// [dv/pin_logic_assertions.sv]
// Purpose: port-level assertions for the power control pin logic
// Assumes: bound to the top module, default bus widths
// Notes: status and mask are not visible here, so checks tie pins together
`timescale 1ns/1ps
module pin_logic_assertions (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [7:0] addr,
	input wire logic wr,
	input wire logic rd,
	input wire logic [31:0] rdata,
	input wire logic regs_on,
	input wire logic sleep_out,
	input wire logic standby_out,
	input wire pin_pkg::od_pin_t host_reset_out_n,
	input wire pin_pkg::od_pin_t irq_out_n
);
	logic mask_wr_r;
	// masks come up all set, so no irq can show before the first mask write
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			mask_wr_r <= 1'b0;
		else if (wr && addr == 8'h08)
			mask_wr_r <= 1'b1;
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	a_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h0)
		else $error("read data not zero outside a read answer");
	a_irq_drive: assert property (irq_out_n.oe |-> !irq_out_n.lvl)
		else $error("irq pin enabled while not pulling low");
	a_irq_masked: assert property (!mask_wr_r |-> !irq_out_n.oe)
		else $error("irq pin low while all masks set");
	a_rst_drive: assert property (host_reset_out_n.oe |->
		!host_reset_out_n.lvl) else $error("reset pin enabled but high");
	a_rst_off: assert property (!regs_on && !sleep_out |->
		host_reset_out_n.oe) else $error("reset released while off");
	a_rst_release: assert property ($rose(regs_on) &&
		!$past(sleep_out) |-> host_reset_out_n.oe [*3])
		else $error("reset released without release delay");
	a_rel_when_on: assert property ($fell(host_reset_out_n.oe) |->
		regs_on) else $error("reset released with regulators off");
	a_stby_on: assert property (standby_out |->
		regs_on && !sleep_out) else $error("standby while off or asleep");
	a_on_sleep: assert property (!(regs_on && sleep_out))
		else $error("on and sleep together");
	c_stby: cover property ($rose(standby_out));
	c_release: cover property ($fell(host_reset_out_n.oe));
	c_irq: cover property ($rose(irq_out_n.oe));
endmodule : pin_logic_assertions
bind pmic_control_pin_logic pin_logic_assertions chk_u (.sys_clk, .rst,
	.addr, .wr, .rd, .rdata, .regs_on, .sleep_out, .standby_out,
	.host_reset_out_n, .irq_out_n);

// [dv/button_host_model.sv]
// Purpose: push button and regulator sequencer at the far side
// Assumes: bench decides when the button is held down
// Notes: a released button reads high; rails report up after a short ramp
`timescale 1ns/1ps
module button_host_model (
	input wire logic sys_clk,
	input wire logic btn_down,
	input wire logic regs_on,
	output logic power_on_input = 1'b1,
	output logic seq_done = 1'b0
);
	logic [1:0] ramp_r = 2'h0;
	always_ff @(posedge sys_clk) begin
		power_on_input <= !btn_down;
		ramp_r <= regs_on ? ramp_r + {1'b0, ramp_r != 2'h3} : 2'h0;
		seq_done <= regs_on && ramp_r == 2'h3;
	end
endmodule : button_host_model

// [dv/tb_pmic_control_pin_logic.sv]
// Purpose: self-checking bench for the power control pin logic
// Assumes: shortened counts, fault timers at their defaults, 2 cycles a tick
// Notes: waits are in ticks with margin over the set counts
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; \
	if ((g) !== (e)) begin n_errors++; \
	$display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module tb_pmic_control_pin_logic;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] addr = 8'h0;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic standby_in = 1'b0;
	logic fault_in = 1'b0;
	logic btn_down = 1'b0;
	logic [31:0] rdata;
	logic power_on_input, seq_done, regs_on, sleep_out, standby_out;
	pin_pkg::od_pin_t host_reset_out_n, irq_out_n;
	int n_errors = 0;
	int comparisons = 0;
	int cycles = 0;
	always #20 sys_clk = !sys_clk;
	// fault timers keep their real counts so their defaults are exercised
	pmic_control_pin_logic #(.TICK_DIV(2), .DB_SHORT(4), .DB_MID(8),
		.LONG_PRESS(40), .REL_BASE(2)) dut_u (.sys_clk, .rst, .addr,
		.wdata, .wr, .rd,
		.rdata, .power_on_input, .standby_in, .fault_in, .seq_done,
		.regs_on, .sleep_out, .standby_out, .host_reset_out_n,
		.irq_out_n);
	button_host_model model_u (.sys_clk, .btn_down, .regs_on,
		.power_on_input, .seq_done);
	task automatic print_verdict();
		$display("comparisons %0d errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : print_verdict
	task automatic tk(input int n);
		repeat (2 * n) @(posedge sys_clk);
		#1;
	endtask : tk
	task automatic w(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge sys_clk);
		wr <= 1'b0;
		#1;
	endtask : w
	task automatic r(input logic [7:0] a, input logic [31:0] e);
		@(posedge sys_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge sys_clk);
		rd <= 1'b0;
		#1;
		`CHK("rdata", e, rdata)
	endtask : r
	task automatic press(input int n);
		btn_down <= 1'b1;
		tk(n);
		btn_down <= 1'b0;
	endtask : press
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			print_verdict();
		end
	end
	initial begin
		repeat (16) @(posedge sys_clk);
		rst <= 1'b0;
		tk(12);
		r(8'h08, 32'hf);
		r(8'h14, 32'h0);
		r(8'h10, 32'h2);
		`CHK("rst_oe", 1'b0, host_reset_out_n.oe)
		btn_down <= 1'b1;
		tk(8);
		r(8'h10, 32'h0);
		`CHK("rst_oe", 1'b1, host_reset_out_n.oe)
		btn_down <= 1'b0;
		tk(12);
		w(8'h0c, 32'hffffffff);
		r(8'h10, 32'h2);
		r(8'h0c, 32'h1);
		// edge mode, long press enabled, middle debounce
		w(8'h00, 32'hb);
		btn_down <= 1'b1;
		tk(52);
		r(8'h04, 32'h0);
		r(8'h10, 32'h0);
		btn_down <= 1'b0;
		tk(6);
		r(8'h10, 32'h0);
		press(5);
		tk(8);
		r(8'h10, 32'h0);
		press(10);
		tk(12);
		r(8'h10, 32'h2);
		r(8'h04, 32'h3);
		`CHK("irq_oe", 1'b0, irq_out_n.oe)
		w(8'h08, 32'h0);
		`CHK("irq_oe", 1'b1, irq_out_n.oe)
		w(8'h04, 32'h3);
		`CHK("irq_oe", 1'b0, irq_out_n.oe)
		r(8'h04, 32'h0);
		press(10);
		tk(8);
		r(8'h10, 32'h2);
		r(8'h04, 32'h3);
		`CHK("irq_oe", 1'b1, irq_out_n.oe)
		w(8'h00, 32'h9);
		btn_down <= 1'b1;
		tk(52);
		r(8'h10, 32'h2);
		btn_down <= 1'b0;
		tk(6);
		standby_in <= 1'b1;
		tk(1);
		`CHK("stby", 1'b0, standby_out)
		tk(7);
		`CHK("stby", 1'b1, standby_out)
		r(8'h10, 32'hb);
		w(8'h00, 32'h19);
		tk(8);
		`CHK("stby", 1'b0, standby_out)
		w(8'h00, 32'h39);
		standby_in <= 1'b0;
		tk(20);
		`CHK("stby", 1'b0, standby_out)
		tk(24);
		`CHK("stby", 1'b1, standby_out)
		standby_in <= 1'b1;
		tk(44);
		`CHK("stby", 1'b0, standby_out)
		// fault mode: reset low at the assert count, off at the off count
		w(8'h00, 32'h99);
		w(8'h04, 32'hf);
		fault_in <= 1'b1;
		tk(55);
		`CHK("rst_oe", 1'b0, host_reset_out_n.oe)
		tk(7);
		`CHK("rst_oe", 1'b1, host_reset_out_n.oe)
		r(8'h04, 32'h4);
		r(8'h0c, 32'hd);
		tk(3200);
		r(8'h10, 32'h2);
		tk(16);
		r(8'h10, 32'h0);
		// a fault still present through start-up keeps the reset held
		press(10);
		tk(12);
		r(8'h10, 32'h1);
		`CHK("rst_oe", 1'b1, host_reset_out_n.oe)
		fault_in <= 1'b0;
		w(8'h00, 32'h98);
		press(10);
		tk(12);
		r(8'h10, 32'h2);
		`CHK("rst_oe", 1'b0, host_reset_out_n.oe)
		// long press with sleep selected, then a brief press wakes it
		w(8'h00, 32'h81b);
		btn_down <= 1'b1;
		tk(52);
		r(8'h10, 32'h4);
		`CHK("sleep", 1'b1, sleep_out)
		`CHK("regs_on", 1'b0, regs_on)
		btn_down <= 1'b0;
		tk(6);
		press(10);
		tk(8);
		r(8'h10, 32'h2);
		`CHK("regs_on", 1'b1, regs_on)
		`CHK("sleep", 1'b0, sleep_out)
		print_verdict();
	end
endmodule : tb_pmic_control_pin_logic
